/* mmai_consts.svh */
`ifndef MMAI_CONSTS_SVH
`define MMAI_CONSTS_SVH

// Byte offsets of the register map
`define MMAI_OFS_CTRL 8'h00
`define MMAI_OFS_CFG 8'h04
`define MMAI_OFS_STATUS 8'h08
`define MMAI_OFS_TXQ 8'h1C
`define MMAI_OFS_ISR 8'h24
`define MMAI_OFS_IEN 8'h28
`define MMAI_OFS_IDIS 8'h2C
`define MMAI_OFS_IMASK 8'h30
`define MMAI_OFS_PHYMAN 8'h34
`define MMAI_OFS_HASH_BOT 8'h90
`define MMAI_OFS_HASH_TOP 8'h94
`define MMAI_OFS_SA1_BOT 8'h98
`define MMAI_OFS_SA1_TOP 8'h9C
`define MMAI_PAIR_STRIDE 8'h08
`define MMAI_NUM_PAIRS 5

// Field positions
`define MMAI_CTRL_RXEN 2
`define MMAI_CTRL_TXEN 3
`define MMAI_CFG_DIV_LSB 16
`define MMAI_CFG_DIV_MSB 18
`define MMAI_CFG_WTC 30
`define MMAI_STAT_MDIO 1
`define MMAI_STAT_IDLE 2
`define MMAI_IRQ_MGMT 0
`define MMAI_NUM_IRQ 18
`define MMAI_MAN_OP_MSB 29
`define MMAI_MAN_OP_LSB 28
`define MMAI_MAN_OP_READ 2'h2
`define MMAI_MAN_HDR_BITS 6'h0E
`define MMAI_MAN_BITS 6'h20

// Write masks and reset values
`define MMAI_CTRL_WMASK 32'h0000000C
`define MMAI_CFG_WMASK 32'h40070000
`define MMAI_CFG_RST 32'h00020000
`define MMAI_TOP_WMASK 32'h0000FFFF
`define MMAI_IRQ_MASK_RST 18'h3FFFF

// Timing
`define MMAI_CLK_PERIOD_NS 100
`define MMAI_MDC_MIN_PERIOD_NS 400
`define MMAI_MDC_MIN_CYCLES ((`MMAI_MDC_MIN_PERIOD_NS + `MMAI_CLK_PERIOD_NS - 1) / `MMAI_CLK_PERIOD_NS)
// MDC division ratio per divider code, code 7 in the top slice
`define MMAI_DIV_TABLE {9'd256, 9'd224, 9'd192, 9'd128, 9'd96, 9'd64, 9'd32, 9'd16}

`endif

/* mmai_pkg.sv */
package mmai_pkg;
	typedef enum logic [0:0] {
		mmai_st_idle = 1'b0,
		mmai_st_shift = 1'b1
	} mmai_mgmt_state_e;
	typedef logic [31:0] mmai_word_t;
endpackage

/* mmai_core_if.sv */
`timescale 1ns/100ps
interface mmai_core_if;
	logic start;
	logic [31:0] cmd;
	logic [2:0] div_sel;
	logic busy;
	logic done;
	logic [31:0] shift_val;
	logic [31:0] addr_lo [0:4];
	logic [15:0] addr_hi [0:4];
	logic [4:0] pair_en;

	modport top (output start, cmd, div_sel, addr_lo, addr_hi, pair_en, input busy, done, shift_val);
	modport mdio (input start, cmd, div_sel, output busy, done, shift_val);
	modport match (input addr_lo, addr_hi, pair_en);
endinterface

/* mmai_mdio_shift.sv */
`timescale 1ns/100ps
`include "mmai_consts.svh"
module mmai_mdio_shift import mmai_pkg::*; #(
	parameter logic [71:0] DIV_TABLE = `MMAI_DIV_TABLE
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, low
	mmai_core_if.mdio core, // Command and status
	input wire logic mdio_i, // MDIO pin level
	output logic mdc, // Management clock
	output logic mdio_o, // MDIO drive value
	output logic mdio_oe // MDIO drive enable
);
	mmai_mgmt_state_e state;
	logic [8:0] ratio;
	logic [7:0] half;
	logic [7:0] half_q;
	logic [7:0] half_cnt;
	logic [5:0] bit_cnt;
	logic [31:0] sr;
	logic sample;
	logic is_read;
	logic tick;

	always_comb begin
		ratio = DIV_TABLE[core.div_sel * 9 +: 9]; // RULE13 RULE21 RULE6
		if (ratio < 9'(`MMAI_MDC_MIN_CYCLES))
			ratio = 9'(`MMAI_MDC_MIN_CYCLES);
		half = ratio[8:1];
	end

	assign tick = (half_cnt == half_q - 8'h01);
	assign core.busy = (state == mmai_st_shift);
	assign core.shift_val = sr; // RULE9
	assign mdio_o = core.busy & sr[31]; // RULE8
	assign mdio_oe = core.busy & (~is_read | (bit_cnt < `MMAI_MAN_HDR_BITS));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= mmai_st_idle;
			half_q <= 8'h01;
			half_cnt <= 8'h00;
			bit_cnt <= 6'h00;
			sr <= 32'h0;
			sample <= 1'b0;
			is_read <= 1'b0;
			mdc <= 1'b0;
			core.done <= 1'b0;
		end else begin
			core.done <= 1'b0;
			case (state)
				mmai_st_idle: begin
					if (core.start) begin // RULE5
						state <= mmai_st_shift;
						sr <= core.cmd;
						half_q <= half;
						half_cnt <= 8'h00;
						bit_cnt <= 6'h00;
						mdc <= 1'b0;
						is_read <= (core.cmd[`MMAI_MAN_OP_MSB:`MMAI_MAN_OP_LSB] == `MMAI_MAN_OP_READ);
					end
				end
				mmai_st_shift: begin
					if (tick) begin
						half_cnt <= 8'h00;
						mdc <= ~mdc;
						if (!mdc) begin
							sample <= mdio_i;
						end else begin
							// Shift on falling edge so MDIO is stable at rise
							sr <= {sr[30:0], sample}; // RULE8 RULE10 RULE20
							bit_cnt <= bit_cnt + 6'h01;
							if (bit_cnt == `MMAI_MAN_BITS - 6'h01) begin
								state <= mmai_st_idle;
								core.done <= 1'b1; // RULE5
							end
						end
					end else begin
						half_cnt <= half_cnt + 8'h01;
					end
				end
				default: state <= mmai_st_idle;
			endcase
		end
	end
endmodule

/* mmai_addr_match.sv */
`timescale 1ns/100ps
`include "mmai_consts.svh"
module mmai_addr_match import mmai_pkg::*; (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, low
	mmai_core_if.match core, // Pair registers
	input wire logic rx_addr_valid, // Destination address strobe
	input wire logic [47:0] rx_addr, // Destination address, first byte low
	output logic [3:0] sa_hit, // Specific address hits
	output logic hash_hit // Hash filter hit
);
	logic [5:0] hidx;
	logic [63:0] hvec;
	logic [3:0] eq;

	assign hvec = {core.addr_hi[0], core.addr_hi[0], core.addr_lo[0]};

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_hash
			assign hidx[g] = rx_addr[g] ^ rx_addr[g + 6] ^ rx_addr[g + 12] ^ rx_addr[g + 18]
				^ rx_addr[g + 24] ^ rx_addr[g + 30] ^ rx_addr[g + 36] ^ rx_addr[g + 42];
		end
		for (g = 0; g < 4; g++) begin : g_sa
			// Bottom holds bytes 0..3, top bytes 4..5
			assign eq[g] = core.pair_en[g + 1] &&
				(rx_addr == {core.addr_hi[g + 1], core.addr_lo[g + 1]}); // RULE1 RULE4 RULE2
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sa_hit <= 4'h0;
			hash_hit <= 1'b0;
		end else if (rx_addr_valid) begin
			sa_hit <= eq;
			hash_hit <= core.pair_en[0] & hvec[hidx]; // RULE1
		end
	end
endmodule

/* mmai_mac_ctrl.sv */
`timescale 1ns/100ps
`include "mmai_consts.svh"
// Operation
// RULE1: One hash and four specific pairs
// RULE2: Bottom write disables, top write re-enables
// RULE3: Pair writes accepted at any time
// RULE4: Bottom bytes 0..3, top bytes 4..5
// RULE5: Maintenance write starts shift, status bit2
// RULE6: Divider code 010 gives about 2000 cycles
// RULE7: Completion raises interrupt condition
// RULE8: MSB out, LSB in each MDC
// RULE9: Read during shift returns live contents
// RULE10: Bits return home; read data from PHY
// RULE11: Software writes well-formed management frames
// RULE12: Software keeps MDC at 2.5 MHz max
// RULE13: MDC divided from clock, 3-bit field
// RULE14: Eighteen conditions ORed onto one line
// RULE15: Status clear on read, or write-one
// RULE16: All sources disabled after reset
// RULE17: Enable/disable by writing ones, zeros ignored
// RULE18: Mask reads one where source disabled
// RULE19: Software loads queue pointer then enables
// RULE20: 32-bit shift, one bit per MDC
// RULE21: Other divider codes fixed, larger ratios; codes 000 and 001 here give smaller ratios, 16 and 32
module mmai_mac_ctrl import mmai_pkg::*; (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write flag
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic hresp, // Response
	output logic [31:0] hrdata, // Read data
	input wire logic [17:0] irq_event, // Datapath event pulses
	input wire logic rx_addr_valid, // Destination address strobe
	input wire logic [47:0] rx_addr, // Destination address
	output logic [3:0] sa_hit, // Specific address hits
	output logic hash_hit, // Hash hit
	output logic rx_enable, // Receive enable
	output logic tx_enable, // Transmit enable
	output logic [31:0] tx_queue_base, // Transmit descriptor list base
	output logic mdc, // Management clock
	input wire logic mdio_i, // MDIO level
	output logic mdio_o, // MDIO drive value
	output logic mdio_oe, // MDIO drive enable
	output logic irq // Interrupt line
);
	mmai_core_if core ();

	logic acc;
	logic rd_acc;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] ctrl;
	logic [31:0] cfg;
	logic [17:0] isr;
	logic [17:0] imask;
	logic [17:0] ev;
	logic [17:0] clr;
	logic [17:0] next_isr;
	logic [17:0] next_imask;
	logic start_q;
	logic [31:0] cmd_q;
	mmai_word_t rd_word;

	function automatic logic wsel(input logic [7:0] ofs);
		wsel = wr_pend && (wr_addr == ofs);
	endfunction

	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign acc = hsel & hready & htrans[1];
	assign rd_acc = acc & ~hwrite;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= acc & hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (rd_acc)
			hrdata <= rd_word;
	end

	// Control and configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= 32'h0;
			cfg <= `MMAI_CFG_RST;
			tx_queue_base <= 32'h0;
		end else begin
			if (wsel(`MMAI_OFS_CTRL))
				ctrl <= hwdata & `MMAI_CTRL_WMASK;
			if (wsel(`MMAI_OFS_CFG))
				cfg <= hwdata & `MMAI_CFG_WMASK; // RULE13
			if (wsel(`MMAI_OFS_TXQ))
				tx_queue_base <= hwdata; // RULE19
		end
	end

	assign rx_enable = ctrl[`MMAI_CTRL_RXEN];
	assign tx_enable = ctrl[`MMAI_CTRL_TXEN];
	assign core.div_sel = cfg[`MMAI_CFG_DIV_MSB:`MMAI_CFG_DIV_LSB];

	// Address pair registers
	genvar p;
	generate
		for (p = 0; p < `MMAI_NUM_PAIRS; p++) begin : g_pair
			localparam logic [7:0] BOT = `MMAI_OFS_HASH_BOT + 8'(p) * `MMAI_PAIR_STRIDE;
			localparam logic [7:0] TOP = BOT + 8'h04;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					core.addr_lo[p] <= 32'h0;
					core.addr_hi[p] <= 16'h0;
					core.pair_en[p] <= 1'b0;
				end else begin
					// No gating by receive enable
					if (wsel(BOT)) begin // RULE3
						core.addr_lo[p] <= hwdata; // RULE4
						core.pair_en[p] <= 1'b0; // RULE2
					end
					if (wsel(TOP)) begin // RULE3
						core.addr_hi[p] <= hwdata[15:0]; // RULE4
						core.pair_en[p] <= 1'b1; // RULE2
					end
				end
			end
		end
	endgenerate

	// Management command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_q <= 1'b0;
			cmd_q <= 32'h0;
		end else begin
			start_q <= wsel(`MMAI_OFS_PHYMAN) & ~core.busy & ~start_q; // RULE5
			if (wsel(`MMAI_OFS_PHYMAN) & ~core.busy & ~start_q)
				cmd_q <= hwdata;
		end
	end

	assign core.start = start_q;
	assign core.cmd = cmd_q;

	// Interrupt status, set beats clear
	always_comb begin
		ev = irq_event;
		ev[`MMAI_IRQ_MGMT] = irq_event[`MMAI_IRQ_MGMT] | core.done; // RULE7
		clr = 18'h0;
		if (cfg[`MMAI_CFG_WTC]) begin
			if (wsel(`MMAI_OFS_ISR))
				clr = hwdata[17:0]; // RULE15
		end else if (rd_acc && haddr[7:0] == `MMAI_OFS_ISR) begin
			clr = isr; // RULE15
		end
		next_isr = (isr & ~clr) | ev;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			isr <= 18'h0;
		else
			isr <= next_isr;
	end

	// Mask seen by irq in the same cycle as the write lands
	always_comb begin
		next_imask = imask;
		if (wsel(`MMAI_OFS_IEN))
			next_imask = next_imask & ~hwdata[17:0]; // RULE17
		if (wsel(`MMAI_OFS_IDIS))
			next_imask = next_imask | hwdata[17:0]; // RULE17
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			imask <= `MMAI_IRQ_MASK_RST; // RULE16
		else
			imask <= next_imask;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(next_isr & ~next_imask); // RULE14
	end

	// Read multiplexer
	always_comb begin
		rd_word = 32'h0;
		case (haddr[7:0])
			`MMAI_OFS_CTRL: rd_word = ctrl;
			`MMAI_OFS_CFG: rd_word = cfg;
			`MMAI_OFS_STATUS: begin
				rd_word[`MMAI_STAT_MDIO] = mdio_i;
				rd_word[`MMAI_STAT_IDLE] = ~core.busy & ~start_q; // RULE5
			end
			`MMAI_OFS_TXQ: rd_word = tx_queue_base;
			`MMAI_OFS_ISR: rd_word = {14'h0, isr};
			`MMAI_OFS_IMASK: rd_word = {14'h0, imask}; // RULE18
			`MMAI_OFS_PHYMAN: rd_word = start_q ? cmd_q : core.shift_val; // RULE9
			default: begin
				for (int i = 0; i < `MMAI_NUM_PAIRS; i++) begin
					if (haddr[7:0] == `MMAI_OFS_HASH_BOT + 8'(i) * `MMAI_PAIR_STRIDE)
						rd_word = core.addr_lo[i];
					if (haddr[7:0] == `MMAI_OFS_HASH_BOT + 8'(i) * `MMAI_PAIR_STRIDE + 8'h04)
						rd_word = {16'h0, core.addr_hi[i]};
				end
			end
		endcase
	end

	mmai_mdio_shift u_mdio (
		.hclk(hclk),
		.hresetn(hresetn),
		.core(core.mdio),
		.mdio_i(mdio_i),
		.mdc(mdc),
		.mdio_o(mdio_o),
		.mdio_oe(mdio_oe)
	);

	mmai_addr_match u_match (
		.hclk(hclk),
		.hresetn(hresetn),
		.core(core.match),
		.rx_addr_valid(rx_addr_valid),
		.rx_addr(rx_addr),
		.sa_hit(sa_hit),
		.hash_hit(hash_hit)
	);
endmodule

/* mmai_mac_ctrl_checker.sv */
`timescale 1ns/100ps
module mmai_mac_ctrl_checker import mmai_pkg::*; (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Type
	input wire logic hwrite, // Write
	input wire logic [31:0] hwdata, // Wdata
	input wire logic hready, // Ready
	input wire logic [31:0] hrdata, // Rdata
	input wire logic [17:0] irq_event, // Events
	input wire logic rx_addr_valid, // Strobe
	input wire logic [3:0] sa_hit, // Hits
	input wire logic hash_hit, // Hash hit
	input wire logic rx_enable, // Rx on
	input wire logic tx_enable, // Tx on
	input wire logic [31:0] tx_queue_base, // Queue
	input wire logic mdc, // MDC
	input wire logic mdio_o, // MDIO out
	input wire logic irq // Irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take;
	logic wr_q;
	assign take = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= take && hwrite;
		end
	end
	sequence s_wr(logic [7:0] ofs);
		take && hwrite && haddr[7:0] == ofs ##1 1'b1;
	endsequence
	a_ctrl_write: assert property (s_wr(8'h00) |=>
		tx_enable == $past(hwdata[3]) && rx_enable == $past(hwdata[2])) else $error("control bits wrong");
	a_txq_write: assert property (s_wr(8'h1C) |=>
		tx_queue_base == $past(hwdata)) else $error("queue pointer wrong");
	a_mdc_high: assert property ($rose(mdc) |-> mdc [*8])
		else $error("mdc high too short");
	a_mdc_low: assert property ($fell(mdc) |-> (!mdc) [*8])
		else $error("mdc low too short");
	a_mdio_when: assert property ($changed(mdio_o) |-> !mdc)
		else $error("mdio moved while mdc high");
	a_match_hold: assert property (!$past(rx_addr_valid) |-> $stable(sa_hit) && $stable(hash_hit))
		else $error("match changed without strobe");
	a_rdata_hold: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
		else $error("read data changed");
	a_irq_cause: assert property ($rose(irq) |-> $past(irq_event) != 18'h0 || $past(wr_q) ||
		($past(mdc, 2) && !$past(mdc))) else $error("irq rose without cause");
endmodule
bind mmai_mac_ctrl mmai_mac_ctrl_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .irq_event, .rx_addr_valid, .sa_hit, .hash_hit, .rx_enable, .tx_enable,
	.tx_queue_base, .mdc, .mdio_o, .irq);

/* mmai_phy_model.sv */
`timescale 1ns/100ps
module mmai_phy_model (
	input wire logic mdc, // Management clock
	input wire logic mdio_o, // Device value
	input wire logic mdio_oe, // Device enable
	input wire logic [15:0] rd_data, // Returned data
	output logic mdio_i, // Wire level
	output logic [31:0] seen // Sampled bits
);
	int cnt = 0;
	logic drv = 1'b1;
	initial seen = 32'h0;
	always @(posedge mdio_oe) cnt = 0;
	always @(posedge mdc) begin
		seen = {seen[30:0], mdio_i};
		cnt = cnt + 1;
	end
	// Turnaround low, data MSB first, else pulled up
	always @(negedge mdc) begin
		if (cnt == 15) begin
			drv <= 1'b0;
		end else if (cnt >= 16 && cnt < 32) begin
			drv <= rd_data[31 - cnt];
		end else begin
			drv <= 1'b1;
		end
	end
	assign mdio_i = mdio_oe ? mdio_o : drv;
endmodule

/* test_mmai_mac_ctrl.sv */
`timescale 1ns/100ps
module test_mmai_mac_ctrl import mmai_pkg::*; ;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rx_addr_valid = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, tx_queue_base, seen;
	logic [1:0] htrans = 2'h0;
	logic [17:0] irq_event = 18'h0;
	logic [47:0] rx_addr = 48'h0;
	logic [3:0] sa_hit;
	logic hready, hreadyout, hresp, hash_hit, rx_enable, tx_enable, mdc, mdio_i, mdio_o, mdio_oe, irq;
	int bad_count = 0, cmp_count = 0, cyc = 0, t0;
	mmai_word_t d;
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	mmai_mac_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .irq_event(irq_event), .rx_addr_valid(rx_addr_valid),
		.rx_addr(rx_addr), .sa_hit(sa_hit), .hash_hit(hash_hit), .rx_enable(rx_enable),
		.tx_enable(tx_enable), .tx_queue_base(tx_queue_base), .mdc(mdc), .mdio_i(mdio_i),
		.mdio_o(mdio_o), .mdio_oe(mdio_oe), .irq(irq));
	mmai_phy_model phy (.mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .rd_data(16'hBEEF),
		.mdio_i(mdio_i), .seen(seen));
	task stop_test();
		$display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge hclk); while (hready !== 1'b1);
		d = hrdata;
	endtask
	task rx(input logic [47:0] a, input logic [3:0] e);
		@(posedge hclk);
		rx_addr <= a;
		rx_addr_valid <= 1'b1;
		@(posedge hclk);
		rx_addr_valid <= 1'b0;
		@(posedge hclk);
		chk(32'(sa_hit), 32'(e));
	endtask
	task t_reset();
		bus(0, 8'h04, 0);
		chk(d, 32'h00020000);
		bus(0, 8'h30, 0);
		chk(d, 32'h0003FFFF);
		bus(0, 8'h40, 0);
		chk(d, 32'h0);
		bus(1, 8'h1C, 32'h00000100);
		bus(1, 8'h00, 32'h0000000C);
		@(negedge hclk);
		chk(32'(tx_enable), 32'h1);
		chk(32'(rx_enable), 32'h1);
		chk(tx_queue_base, 32'h00000100);
		chk(32'(hresp), 32'h0);
	endtask
	task t_match();
		bus(1, 8'h98, 32'h87654321);
		bus(1, 8'h9C, 32'hFFFFCBA9);
		bus(0, 8'h9C, 0);
		chk(d, 32'h0000CBA9);
		rx(48'hCBA987654321, 4'h1);
		bus(1, 8'h98, 32'h87654321);
		rx(48'hCBA987654321, 4'h0);
		bus(1, 8'h9C, 32'h0000CBA9);
		rx(48'hCBA987654321, 4'h1);
		bus(1, 8'hB0, 32'h33221100);
		bus(1, 8'hB4, 32'h00005544);
		bus(1, 8'h90, 32'hFFFFFFFF);
		bus(1, 8'h94, 32'h0000FFFF);
		rx(48'h554433221100, 4'h8);
		chk(32'(hash_hit), 32'h1);
	endtask
	task t_irq();
		bus(1, 8'h28, 32'h2);
		bus(1, 8'h2C, 32'h0);
		bus(0, 8'h30, 0);
		chk(d, 32'h0003FFFD);
		@(posedge hclk);
		irq_event <= 18'h3FFFF;
		@(posedge hclk);
		irq_event <= 18'h0;
		@(posedge hclk);
		chk(32'(irq), 32'h1);
		bus(0, 8'h24, 0);
		chk(d, 32'h0003FFFF);
		bus(0, 8'h24, 0);
		chk(d, 32'h0);
		chk(32'(irq), 32'h0);
		bus(1, 8'h2C, 32'h2);
		bus(0, 8'h30, 0);
		chk(d, 32'h0003FFFF);
		bus(1, 8'h04, 32'h40020000);
		@(posedge hclk);
		irq_event <= 18'h20000;
		@(posedge hclk);
		irq_event <= 18'h0;
		bus(0, 8'h24, 0);
		bus(0, 8'h24, 0);
		chk(d, 32'h00020000);
		bus(1, 8'h24, 32'h00020000);
		bus(0, 8'h24, 0);
		chk(d, 32'h0);
		bus(1, 8'h04, 32'h00020000);
	endtask
	// Well-formed frames only
	task t_mgmt(input logic [31:0] c, input logic [31:0] e);
		bus(1, 8'h34, c);
		t0 = cyc;
		bus(0, 8'h08, 0);
		chk(32'(d[2]), 32'h0);
		// Lands after the first MDC fall, before the second
		repeat (100) @(posedge hclk);
		bus(0, 8'h34, 0);
		chk(d, {c[30:0], c[31]});
		do bus(0, 8'h08, 0); while (d[2] !== 1'b1);
		chk(32'(d[1]), 32'h1);
		chk(32'(irq), 32'h1);
		chk(32'(cyc - t0 > 1900 && cyc - t0 < 2200), 32'h1);
		bus(0, 8'h34, 0);
		chk(d, e);
		bus(0, 8'h24, 0);
		chk(32'(d[0]), 32'h1);
		chk(32'(irq), 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_match();
		t_irq();
		bus(1, 8'h28, 32'h00000001);
		t_mgmt(32'h608A0000, 32'h608ABEEF);
		t_mgmt(32'h508A1234, 32'h508A1234);
		chk(seen, 32'h508A1234);
		stop_test();
	end
endmodule
